// File: dtp_cfg.svh
// constants for the dual timer pair: register indexes, field positions, reset values
// assumes: included by bare name from the timer pair module
`ifndef DTP_CFG_SVH
`define DTP_CFG_SVH

// ********************
// register indexes (byte address is four times the index)
// ********************
`define DTP_IDX_BYTE_CTRL   4'h0
`define DTP_IDX_COMMON      4'h1
`define DTP_IDX_WORD_CTRL   4'h2
`define DTP_IDX_BYTE_LO     4'h4
`define DTP_IDX_BYTE_HI     4'h5
`define DTP_IDX_WORD_LSB    4'h6
`define DTP_IDX_WORD_MSB    4'h7
`define DTP_IDX_CAP_LSB     4'h8
`define DTP_IDX_CAP_MSB     4'h9

// ********************
// field positions
// ********************
`define DTP_BIT_ENABLE      7
`define DTP_BIT_SINGLE      6
`define DTP_BIT_TIMEOUT     5
`define DTP_BIT_CAP_IE      2
`define DTP_BIT_TO_IE       1
`define DTP_BIT_MODE        7
`define DTP_BIT_SELECT      6
`define DTP_BIT_INIT8       1
`define DTP_BIT_INIT16      0

// ********************
// reset values and counts
// ********************
`define DTP_RST_BYTE        8'h00
`define DTP_RST_WORD        16'h0000
`define DTP_WORD_ALL_ONES   16'hffff
`define DTP_SUB_NORMAL      2'b00
`define DTP_SUB_PINGPONG    2'b01

`endif

// File: dtp_pkg.sv
// types for the dual timer pair: combine and edge encodings, whole-block state
// assumes: compiled before dtp_timer_pair
package dtp_pkg;

  typedef enum logic [1:0] {
    DTP_CMB_AND  = 2'b00,
    DTP_CMB_OR   = 2'b01,
    DTP_CMB_NOR  = 2'b10,
    DTP_CMB_NAND = 2'b11
  } dtp_comb_e;

  typedef enum logic [1:0] {
    DTP_EDGE_FALL = 2'b00,
    DTP_EDGE_RISE = 2'b01,
    DTP_EDGE_BOTH = 2'b10,
    DTP_EDGE_NONE = 2'b11
  } dtp_edge_e;

  typedef struct packed {
    logic        mode;
    logic        sel;
    logic [1:0]  comb;
    logic [1:0]  sub;
    logic [1:0]  lo2;
    logic        b_en;
    logic        b_single;
    logic        b_to;
    logic [4:0]  b_low;
    logic        w_en;
    logic        w_single;
    logic        w_to;
    logic [4:0]  w_low;
    logic [7:0]  hold8_hi;
    logic [7:0]  hold8_lo;
    logic [15:0] hold16;
    logic [15:0] cap;
    logic [7:0]  b_cnt;
    logic [15:0] w_cnt;
    logic        b_out;
    logic        w_out;
    logic        w_armed;
    logic [2:0]  sync;
    logic        din;
    logic        ack;
    logic [7:0]  rdat;
    logic        b_irq;
    logic        w_irq;
    logic        pin;
  } dtp_state_s;

endpackage : dtp_pkg

// File: dtp_pulse_src.sv
// outside pulse source: drives both demodulator input pins
// assumes: the bench asks for each pin edge by a one-cycle flip request
`timescale 1ns/1ps
`default_nettype none
// ********************
// pulse source
// ********************
module dtp_pulse_src (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic flip_a_i,
  input  wire logic flip_b_i,
  output logic      pin_a_o,
  output logic      pin_b_o
);
  // pins move on clock edges only; the block resynchronises them anyway
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_o <= 1'b0;
      pin_b_o <= 1'b0;
    end else begin
      pin_a_o <= pin_a_o ^ flip_a_i;
      pin_b_o <= pin_b_o ^ flip_b_i;
    end
  end
endmodule : dtp_pulse_src
`default_nettype wire

// File: dtp_timer_pair.sv
// byte and word counter/timer pair with common control, wishbone register slave
// assumes: one 10 MHz clock, synchronous active-high reset, pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "dtp_cfg.svh"

// Behaviour
// - transmit: common bit1 sets byte output start level
// - transmit: common bit0 sets word output start level
// - demod: bits1/0 edge flags, write one clears
// - mode bit: 0 transmit, 1 demodulation
// - transmit: select bit routes combined output to pin
// - demod: select bit picks input pin a/b
// - transmit: field combines outputs and/or/nor/nand
// - demod: field picks falling, rising or both edges
// - transmit: submode normal or ping-pong
// - demod single-pass: word timer ignores later edges
// - demod single-pass: byte timeout captures word count, optional irq
// - single-pass bit zero then one re-arms capture
// - demod: word timer wraps to all-ones, timeout flag, optional irq
// - ping-pong byte start: output init, hold loaded
// - byte terminal: byte off, word started with init
// - word terminal: word off, byte restarted
// - hardware alternates the two enable bits
// - timeout bit set at every terminal count
// - each terminal count may raise its irq
// - submode 00 stops ping-pong
// - word timer drives fourth irq, byte fifth
module dtp_timer_pair
  import dtp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        demod_input_pin_a_i,
  input  wire logic        demod_input_pin_b_i,
  input  wire logic        shared_port_data_i,
  output logic             shared_output_pin_o,
  output logic             byte_timer_output_o,
  output logic             word_timer_output_o,
  output logic             word_timer_irq_o,
  output logic             byte_timer_irq_o
);

  dtp_state_s  s_q;
  dtp_state_s  s_d;
  logic        wr;
  logic [3:0]  idx;
  logic [7:0]  wd;
  logic [7:0]  rd_val;
  logic        pp;
  logic        b_start;
  logic        w_start;
  logic        b_term;
  logic        w_term;
  logic        rise;
  logic        fall;
  logic        rise_set;
  logic        fall_set;
  logic        edge_hit;
  logic        w_edge_take;
  logic        comb_val;
  logic        pin_sel;

  // ********************
  // register read mux
  // ********************
  always_comb begin
    case (idx)
      `DTP_IDX_BYTE_CTRL: rd_val = {s_q.b_en, s_q.b_single, s_q.b_to, s_q.b_low};
      `DTP_IDX_COMMON:    rd_val = {s_q.mode, s_q.sel, s_q.comb, s_q.sub, s_q.lo2};
      `DTP_IDX_WORD_CTRL: rd_val = {s_q.w_en, s_q.w_single, s_q.w_to, s_q.w_low};
      `DTP_IDX_BYTE_LO:   rd_val = s_q.hold8_lo;
      `DTP_IDX_BYTE_HI:   rd_val = s_q.hold8_hi;
      `DTP_IDX_WORD_LSB:  rd_val = s_q.hold16[7:0];
      `DTP_IDX_WORD_MSB:  rd_val = s_q.hold16[15:8];
      `DTP_IDX_CAP_LSB:   rd_val = s_q.cap[7:0];
      `DTP_IDX_CAP_MSB:   rd_val = s_q.cap[15:8];
      default:            rd_val = 8'h00;
    endcase
    if (wb_adr_i[7:6] != 2'b00) begin
      rd_val = 8'h00;
    end
  end

  // ********************
  // next-state logic
  // ********************
  always_comb begin
    s_d         = s_q;
    b_start     = 1'b0;
    w_start     = 1'b0;
    b_term      = 1'b0;
    w_term      = 1'b0;
    w_edge_take = 1'b0;
    idx         = wb_adr_i[5:2];
    wd          = wb_dat_i[7:0];
    // write lands on the edge where the master sees ack
    wr          = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack && wb_sel_i[0] && (wb_adr_i[7:6] == 2'b00);
    pp          = !s_q.mode && (s_q.sub == `DTP_SUB_PINGPONG);
    s_d.ack     = wb_cyc_i && wb_stb_i && !s_q.ack;
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.rdat = rd_val;
    end
    s_d.b_irq   = 1'b0;
    s_d.w_irq   = 1'b0;

    // input path: mux before the synchroniser, change counted once stages 2 and 3 agree
    pin_sel  = s_q.sel ? demod_input_pin_b_i : demod_input_pin_a_i;
    s_d.sync = {s_q.sync[1:0], pin_sel};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.din = s_q.sync[2];
    end
    rise = s_d.din && !s_q.din;
    fall = !s_d.din && s_q.din;
    case (dtp_edge_e'(s_q.comb))
      DTP_EDGE_FALL: begin
        rise_set = 1'b0;
        fall_set = fall;
      end
      DTP_EDGE_RISE: begin
        rise_set = rise;
        fall_set = 1'b0;
      end
      DTP_EDGE_BOTH: begin
        rise_set = rise;
        fall_set = fall;
      end
      default: begin
        rise_set = 1'b0;
        fall_set = 1'b0;
      end
    endcase
    rise_set = rise_set && s_q.mode;
    fall_set = fall_set && s_q.mode;
    edge_hit = rise_set || fall_set;

    // software writes
    if (wr) begin
      case (idx)
        `DTP_IDX_BYTE_CTRL: begin
          s_d.b_single = wd[`DTP_BIT_SINGLE];
          s_d.b_low    = wd[4:0];
          if (wd[`DTP_BIT_TIMEOUT]) begin
            s_d.b_to = 1'b0;
          end
          if (!wd[`DTP_BIT_ENABLE]) begin
            s_d.b_en = 1'b0;
          end else if (!s_q.b_en) begin
            b_start = 1'b1;
          end
        end
        `DTP_IDX_COMMON: begin
          s_d.mode = wd[`DTP_BIT_MODE];
          s_d.sel  = wd[`DTP_BIT_SELECT];
          s_d.comb = wd[5:4];
          s_d.sub  = wd[3:2];
          // same bits: levels in transmit, write-one-clear flags in demod
          if (s_q.mode) begin
            s_d.lo2 = s_q.lo2 & ~wd[1:0];
          end else begin
            s_d.lo2 = wd[1:0];
          end
        end
        `DTP_IDX_WORD_CTRL: begin
          s_d.w_single = wd[`DTP_BIT_SINGLE];
          s_d.w_low    = wd[4:0];
          if (wd[`DTP_BIT_SINGLE] && !s_q.w_single) begin
            s_d.w_armed = 1'b1;
          end
          if (wd[`DTP_BIT_TIMEOUT]) begin
            s_d.w_to = 1'b0;
          end
          if (!wd[`DTP_BIT_ENABLE]) begin
            s_d.w_en = 1'b0;
          end else if (!s_q.w_en) begin
            w_start = 1'b1;
          end
        end
        `DTP_IDX_BYTE_LO:  s_d.hold8_lo      = wd;
        `DTP_IDX_BYTE_HI:  s_d.hold8_hi      = wd;
        `DTP_IDX_WORD_LSB: s_d.hold16[7:0]   = wd;
        `DTP_IDX_WORD_MSB: s_d.hold16[15:8]  = wd;
        default: begin
        end
      endcase
    end

    // ********************
    // byte timer
    // ********************
    if (s_q.b_en) begin
      if (s_q.b_cnt == `DTP_RST_BYTE) begin
        b_term = 1'b1;
      end else begin
        s_d.b_cnt = s_q.b_cnt - 8'h01;
      end
    end
    if (b_term) begin
      s_d.b_to  = 1'b1;
      s_d.b_out = !s_q.b_out;
      if (s_q.b_low[`DTP_BIT_TO_IE]) begin
        s_d.b_irq = 1'b1;
      end
      if (pp) begin
        s_d.b_en = 1'b0;
        w_start  = 1'b1;
      end else if (s_q.b_single) begin
        s_d.b_en = 1'b0;
      end else begin
        s_d.b_cnt = s_q.b_out ? s_q.hold8_lo : s_q.hold8_hi;
      end
      // demod single-pass: byte timeout snapshots the running word count
      if (s_q.mode && s_q.w_en && s_q.w_single) begin
        s_d.cap = s_q.w_cnt;
        if (s_q.w_low[`DTP_BIT_CAP_IE]) begin
          s_d.w_irq = 1'b1;
        end
      end
    end

    // ********************
    // word timer
    // ********************
    if (s_q.w_en) begin
      if (s_q.w_cnt == `DTP_RST_WORD) begin
        w_term = 1'b1;
        s_d.w_cnt = s_q.mode ? `DTP_WORD_ALL_ONES : s_q.hold16;
      end else begin
        s_d.w_cnt = s_q.w_cnt - 16'h0001;
      end
    end
    if (w_term) begin
      s_d.w_to = 1'b1;
      if (s_q.w_low[`DTP_BIT_TO_IE]) begin
        s_d.w_irq = 1'b1;
      end
      if (!s_q.mode) begin
        s_d.w_out = !s_q.w_out;
        if (pp) begin
          s_d.w_en = 1'b0;
          b_start  = 1'b1;
        end else if (s_q.w_single) begin
          s_d.w_en = 1'b0;
        end
      end
    end
    // single-pass takes only the first edge after arming
    if (s_q.w_en && edge_hit && (!s_q.w_single || s_q.w_armed)) begin
      w_edge_take = 1'b1;
      s_d.cap     = s_q.w_cnt;
      s_d.w_cnt   = s_q.hold16;
      s_d.w_armed = 1'b0;
      if (s_q.w_low[`DTP_BIT_CAP_IE]) begin
        s_d.w_irq = 1'b1;
      end
    end

    // starts load hold values, and in transmit also the initial output levels
    if (b_start) begin
      s_d.b_en  = 1'b1;
      s_d.b_cnt = s_q.lo2[`DTP_BIT_INIT8] ? s_q.hold8_hi : s_q.hold8_lo;
      if (!s_q.mode) begin
        s_d.b_out = s_q.lo2[`DTP_BIT_INIT8];
      end
    end
    if (w_start) begin
      s_d.w_en    = 1'b1;
      s_d.w_cnt   = s_q.hold16;
      s_d.w_armed = 1'b1;
      if (!s_q.mode) begin
        s_d.w_out = s_q.lo2[`DTP_BIT_INIT16];
      end
    end
    if (!s_q.mode && s_q.sub[1]) begin
      s_d.w_out = s_q.sub[0];
    end

    // edge flags: set wins over a same-cycle clear
    if (rise_set) begin
      s_d.lo2[`DTP_BIT_INIT8] = 1'b1;
    end
    if (fall_set) begin
      s_d.lo2[`DTP_BIT_INIT16] = 1'b1;
    end

    // ********************
    // output combiner
    // ********************
    case (dtp_comb_e'(s_q.comb))
      DTP_CMB_AND:  comb_val = s_q.b_out & s_q.w_out;
      DTP_CMB_OR:   comb_val = s_q.b_out | s_q.w_out;
      DTP_CMB_NOR:  comb_val = !(s_q.b_out | s_q.w_out);
      DTP_CMB_NAND: comb_val = !(s_q.b_out & s_q.w_out);
      default:      comb_val = 1'b0;
    endcase
    s_d.pin = (!s_q.mode && s_q.sel) ? comb_val : shared_port_data_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o            = s_q.ack;
  assign wb_dat_o            = {24'h00_0000, s_q.rdat};
  assign shared_output_pin_o = s_q.pin;
  assign byte_timer_output_o = s_q.b_out;
  assign word_timer_output_o = s_q.w_out;
  assign word_timer_irq_o    = s_q.w_irq;
  assign byte_timer_irq_o    = s_q.b_irq;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  init_byte_a: assert property (b_start && !s_q.mode |=> byte_timer_output_o == $past(s_q.lo2[1]))
    else $error("byte output did not take its initial level");
  init_word_a: assert property (w_start && !s_q.mode && !s_q.sub[1] && !s_q.w_en
                                |=> word_timer_output_o == $past(s_q.lo2[0]))
    else $error("word output did not take its initial level");
  flag_clear_a: assert property (wr && idx == `DTP_IDX_COMMON && s_q.mode && wd[1] && !rise_set
                                 |=> !s_q.lo2[1])
    else $error("rising edge flag not cleared by write");
  pin_route_a: assert property (!s_q.mode && s_q.sel |=> shared_output_pin_o == $past(comb_val))
    else $error("shared pin does not carry combined output");
  word_wrap_a: assert property (s_q.mode && s_q.w_en && s_q.w_cnt == 16'h0000 && !w_edge_take
                                |=> s_q.w_cnt == 16'hffff && s_q.w_to)
    else $error("word timer did not wrap to all ones");
  single_pass_a: assert property (s_q.mode && s_q.w_en && s_q.w_single && !s_q.w_armed && edge_hit && !b_term
                                  |=> $stable(s_q.cap))
    else $error("single pass captured a later edge");
  pp_handoff_a: assert property (pp && b_term && !wr |=> !s_q.b_en && s_q.w_en)
    else $error("ping-pong did not hand byte to word timer");
  pp_return_a: assert property (pp && w_term && !wr |=> s_q.b_en && !s_q.w_en)
    else $error("ping-pong did not return to byte timer");
  byte_irq_a: assert property (b_term && s_q.b_low[1] |=> byte_timer_irq_o)
    else $error("byte timer irq missing at terminal count");
  byte_irq_quiet_a: assert property (!(b_term && s_q.b_low[1]) |=> !byte_timer_irq_o)
    else $error("byte timer irq without an enabled terminal count");
  word_irq_quiet_a: assert property (!(w_term || b_term || w_edge_take) |=> !word_timer_irq_o)
    else $error("word timer irq without a cause");
  rise_flag_set_a: assert property (rise_set |=> s_q.lo2[1])
    else $error("rising edge flag not set");

  pp_cycle_c: cover property (pp && b_term ##[1:600] pp && w_term);
  demod_cap_c: cover property (w_edge_take && s_q.w_single);
  pin_comb_c: cover property (!s_q.mode && s_q.sel && s_q.b_en && s_q.w_en);
  demod_wrap_c: cover property (s_q.mode && w_term);
  both_edges_c: cover property (rise_set ##[1:100] fall_set);

endmodule : dtp_timer_pair
`default_nettype wire

// File: test_dual_timer_pulse_transmit_demod.sv
// self-checking bench for the timer pair: wishbone tasks, one task per scenario
// assumes: dtp_timer_pair and dtp_pulse_src compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_pulse_transmit_demod;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, port_dat = 0, fa = 0, fb = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, pin_a, pin_b, pin_o, b_out, w_out, w_irq, b_irq;
  int          err_count = 0, compares = 0;
  logic [7:0]  q;

  dtp_timer_pair dtp_timer_pair_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .demod_input_pin_a_i(pin_a), .demod_input_pin_b_i(pin_b), .shared_port_data_i(port_dat),
    .shared_output_pin_o(pin_o), .byte_timer_output_o(b_out), .word_timer_output_o(w_out),
    .word_timer_irq_o(w_irq), .byte_timer_irq_o(b_irq));
  dtp_pulse_src dtp_pulse_src_inst (.clk_i(clk), .rst_i(rst), .flip_a_i(fa), .flip_b_i(fb),
    .pin_a_o(pin_a), .pin_b_o(pin_b));

  // ********************
  // shared tasks
  // ********************
  task check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : check

  // one classic cycle; the gap cycle after it keeps requests apart
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask : xfer

  task wr(input logic [3:0] i, input logic [7:0] d);
    xfer(1'b1, {2'b00, i, 2'b00}, d);
  endtask : wr

  task rd(input logic [3:0] i);
    xfer(1'b0, {2'b00, i, 2'b00}, 8'h00);
  endtask : rd

  task wait_irq(input bit w, input string nm);
    int n;
    n = 0;
    while (((w ? w_irq : b_irq) !== 1'b1) && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(nm, {7'h00, n < 300}, 8'h01);
  endtask : wait_irq

  // settle span of the input synchroniser plus the flag edge
  task flip(input bit b);
    if (b) fb <= 1; else fa <= 1;
    @(posedge clk);
    fa <= 0; fb <= 0;
    repeat (8) @(posedge clk);
  endtask : flip

  // ********************
  // scenarios
  // ********************
  task t_reset;
    rd(4'h1); check("common reset", q, 8'h00);
    wr(4'h3, 8'h5a); rd(4'h3); check("unmapped", q, 8'h00);
    xfer(1'b0, 8'h40, 8'h00); check("high adr", q, 8'h00);
  endtask : t_reset

  task t_combine;
    port_dat <= 1; wr(4'h1, 8'h00); repeat (3) @(posedge clk);
    check("port path", {7'h00, pin_o}, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(4'h1, 8'(8'h40 | (c << 4))); repeat (3) @(posedge clk);
      check("combine", {7'h00, pin_o}, {7'h00, c >= 2});
    end
    // submode 11 forces the word output high, so AND and NOR give low, OR and NAND give high
    for (int c = 0; c < 4; c++) begin
      wr(4'h1, 8'(8'h4c | (c << 4))); repeat (3) @(posedge clk);
      check("combine w1", {7'h00, pin_o}, {7'h00, c[0]});
    end
    wr(4'h1, 8'h08);
  endtask : t_combine

  task t_levels;
    wr(4'h5, 8'h20); wr(4'h6, 8'h20); wr(4'h7, 8'h00); wr(4'h1, 8'h03);
    wr(4'h0, 8'hc2); wr(4'h2, 8'hc0); @(posedge clk);
    check("byte start", {7'h00, b_out}, 8'h01);
    check("word start", {7'h00, w_out}, 8'h01);
    wait_irq(1'b0, "byte irq");
    @(posedge clk); check("byte toggled", {7'h00, b_out}, 8'h00);
    rd(4'h0); check("byte ctrl", q, 8'h62);
    wr(4'h0, 8'h60); wr(4'h2, 8'h20); rd(4'h0); check("to clear", q, 8'h40);
  endtask : t_levels

  task t_pingpong;
    wr(4'h0, 8'h60); wr(4'h2, 8'h60);
    wr(4'h4, 8'h10); wr(4'h5, 8'h10); wr(4'h6, 8'h18);
    wr(4'h0, 8'h42); wr(4'h2, 8'h42); wr(4'h1, 8'h07);
    wr(4'h0, 8'hc2); @(posedge clk);
    check("pp byte init", {7'h00, b_out}, 8'h01);
    wait_irq(1'b0, "pp byte irq");
    rd(4'h2); check("word on", q & 8'h80, 8'h80);
    check("word init", {7'h00, w_out}, 8'h01);
    rd(4'h0); check("byte off", q & 8'ha0, 8'h20);
    wait_irq(1'b1, "pp word irq");
    rd(4'h0); check("byte again", q & 8'h80, 8'h80);
    rd(4'h2); check("word to", q & 8'ha0, 8'h20);
    wr(4'h1, 8'h02); repeat (60) @(posedge clk);
    rd(4'h0); check("stop byte", q & 8'h80, 8'h00);
    rd(4'h2); check("stop word", q & 8'h80, 8'h00);
  endtask : t_pingpong

  task t_edges;
    wr(4'h0, 8'h20); wr(4'h2, 8'h20);
    // still in transmit while this lands, so bits 1:0 are stored as levels
    wr(4'h1, 8'h90); flip(1'b0);
    rd(4'h1); check("rise flag", q & 8'h03, 8'h02);
    wr(4'h1, 8'h92); rd(4'h1); check("rise clear", q & 8'h03, 8'h00);
    flip(1'b0); rd(4'h1); check("fall ignored", q & 8'h03, 8'h00);
    wr(4'h1, 8'hc3); flip(1'b0);
    rd(4'h1); check("pin a unused", q & 8'h03, 8'h00);
    flip(1'b1); flip(1'b1);
    rd(4'h1); check("fall flag", q & 8'h03, 8'h01);
    wr(4'h1, 8'he3); flip(1'b1); flip(1'b1);
    rd(4'h1); check("both flags", q & 8'h03, 8'h03);
  endtask : t_edges

  task t_capture;
    wr(4'h6, 8'h00); wr(4'h7, 8'h10); wr(4'h2, 8'hc4);
    wr(4'h4, 8'h0a); wr(4'h0, 8'h80);
    wait_irq(1'b1, "cap irq");
    rd(4'h9); check("cap msb", q, 8'h0f);
    wr(4'h9, 8'h55); rd(4'h9); check("cap ro", q, 8'h0f);
    wr(4'h0, 8'h20);
    flip(1'b1); flip(1'b1); rd(4'h2); check("single keeps", q & 8'h80, 8'h80);
    wr(4'h2, 8'h00); wr(4'h6, 8'h08); wr(4'h7, 8'h00); wr(4'h2, 8'hc2);
    wait_irq(1'b1, "wrap irq");
    rd(4'h2); check("wrap to", q & 8'h20, 8'h20);
    flip(1'b1); rd(4'h9); check("wrap count", q, 8'hff);
  endtask : t_capture

  // ********************
  // run control
  // ********************
  task wrap_up;
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset();
    t_combine();
    t_levels();
    t_pingpong();
    t_edges();
    t_capture();
    wrap_up();
  end
endmodule : test_dual_timer_pulse_transmit_demod
`default_nettype wire
